// *** dpo_pkg.sv ***
// Constants and types shared by the parallel output port
package dpo_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STRAP_WAIT_NS = 1000;
  localparam int STRAP_CYC = (STRAP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_CW = $clog2(STRAP_CYC + 1);
  localparam logic [1:0] FILT_MIN_PULSE = 2'h3;
  localparam logic [7:0] RATE_WINDOW = 8'h82;
  localparam int DE_HS_MAX_TRANS = 2;
  localparam int VS_MAX_TRANS = 1;
  localparam int DATA_W = 24;
  localparam int CAP_W = 27;
  localparam int CAP_DE = 24;
  localparam int CAP_HS = 25;
  localparam int CAP_VS = 26;
  localparam int STRAP_CFG1_BIT = 22;
  localparam int STRAP_CFG0_BIT = 23;
  localparam int STRAP_LF_BIT = 20;
  localparam int STRAP_OSS_BIT = 18;
  localparam int STRAP_RFB_BIT = 17;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam int CTRL_LF_OVR = 0;
  localparam int CTRL_LF_VAL = 1;
  localparam int CTRL_RFB_OVR = 2;
  localparam int CTRL_RFB_VAL = 3;
  localparam int CTRL_OSS_OVR = 4;
  localparam int CTRL_OSS_VAL = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int INT_LOCK = 0;
  localparam int INT_BIST = 1;
  localparam int INT_DROP = 2;
  localparam int INT_RATE = 3;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  typedef enum logic [1:0] {DPO_MODE_FILT_OFF, DPO_MODE_FILT_ON, DPO_MODE_LEGACY_A, DPO_MODE_LEGACY_B} dpo_mode_t;
  typedef enum logic {DPO_PH_STRAP, DPO_PH_RUN} dpo_phase_t;
endpackage

// *** dpo_ctl_if.sv ***
// Carrier between the output port and one control-signal filter
`timescale 1ns/1ps
interface dpo_ctl_if;
  logic stb;
  logic raw;
  logic filt_en;
  logic fwd;
  logic drop;
  logic viol;
  modport filt (input stb, input raw, input filt_en, output fwd, output drop, output viol);
  modport port (output stb, output raw, output filt_en, input fwd, input drop, input viol);
endinterface

// *** dpo_ctl_filter.sv ***
// Control-signal pulse filter and transition-rate limiter
`timescale 1ns/1ps
module dpo_ctl_filter
  import dpo_pkg::*;
#(
  parameter int MAX_TRANS = 2
)
(
  input wire logic MCLK,
  input wire logic RESET_N,
  dpo_ctl_if.filt ctl
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic fwd;
    logic [1:0] run;
    logic [7:0] age_a;
    logic [7:0] age_b;
  } dpo_filt_t;

  localparam dpo_filt_t FILT_RST = '{fwd: 1'b0, run: 2'h0, age_a: RATE_WINDOW, age_b: RATE_WINDOW};

  dpo_filt_t q;
  dpo_filt_t d;
  logic want;
  logic gate_ok;
  logic [7:0] gate_age;

  function automatic logic [7:0] sat_age(input logic [7:0] a);
    sat_age = (a >= RATE_WINDOW) ? RATE_WINDOW : a + 8'h01;
  endfunction

  assign gate_age = (MAX_TRANS == 1) ? q.age_a : q.age_b;
  assign gate_ok = gate_age >= RATE_WINDOW;
  assign ctl.fwd = q.fwd;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    want = 1'b0;
    ctl.drop = 1'b0;
    ctl.viol = 1'b0;
    if (ctl.stb)
    begin
      d.age_a = sat_age(q.age_a);
      d.age_b = sat_age(q.age_b);
      if (ctl.raw == q.fwd)
      begin
        ctl.drop = ctl.filt_en && (q.run != 2'h0);
        d.run = 2'h0;
      end
      else
      begin
        d.run = (q.run == FILT_MIN_PULSE) ? q.run : q.run + 2'h1;
        want = ctl.filt_en ? (d.run >= FILT_MIN_PULSE) : 1'b1;
      end
      if (want && gate_ok)
      begin
        d.fwd = ctl.raw;
        d.run = 2'h0;
        d.age_a = 8'h00;
        d.age_b = q.age_a;
      end
      else if (want)
      begin
        ctl.viol = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      q <= FILT_RST;
    else
      q <= d;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  a_filter_min_pulse: assert property (
    $changed(q.fwd) && $past(ctl.filt_en) |-> $past(q.run) >= FILT_MIN_PULSE - 2'h1 && $past(ctl.raw) == q.fwd)
    else $error("filtered control changed before three strobes");
  a_nofilter_pass: assert property (
    ctl.stb && !ctl.filt_en && ctl.raw != q.fwd && gate_ok |=> q.fwd == $past(ctl.raw))
    else $error("unfiltered control transition not forwarded");
  a_rate_window: assert property (
    $changed(q.fwd) |-> $past(gate_age) >= RATE_WINDOW)
    else $error("control transition inside rate window");
endmodule

// *** dpo_parallel_out.sv ***
// Parallel output port of the serial-link deserializer
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module dpo_parallel_out
  import dpo_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic POWER_DOWN_N,
  input wire logic PLL_LOCKED,
  input wire logic LINK_CLK,
  input wire logic [DATA_W-1:0] RX_DATA,
  input wire logic RX_DE,
  input wire logic RX_HS,
  input wire logic RX_VS,
  input wire logic BIST_EN,
  input wire logic RX_ERROR,
  input wire logic SSCG_EN,
  input wire logic [DATA_W-1:0] DO_IN,
  output logic [DATA_W-1:0] DO_OUT,
  output logic [DATA_W-1:0] DO_OE,
  output logic DATA_ENABLE_OUT,
  output logic HSYNC_OUT,
  output logic VSYNC_OUT,
  output logic PIXEL_CLOCK_OUT,
  output logic CTRL_OE,
  output logic LOCK_OUT,
  output logic PASS_OUT,
  output logic SPREAD_LOW_RANGE,
  output logic IRQ,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dpo_phase_t phase;
    logic [STRAP_CW-1:0] scnt;
    logic [2:0] lk;
    logic pdn1;
    logic pdn2;
    logic lok1;
    logic lok2;
    logic bist1;
    logic bist2;
    logic err1;
    logic err2;
    logic ssc1;
    logic ssc2;
    logic [CAP_W-1:0] rx1;
    logic [CAP_W-1:0] rx2;
    logic [DATA_W-1:0] din1;
    logic [DATA_W-1:0] din2;
    logic [CAP_W-1:0] cap;
    logic [1:0] mode;
    logic s_lf;
    logic s_oss;
    logic s_rfb;
    logic [5:0] ctrl;
    logic [3:0] ists;
    logic [3:0] imask;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic de;
    logic hs;
    logic vs;
    logic pck;
    logic coe;
    logic lock;
    logic pass;
    logic lowr;
    logic [31:0] rdata;
  } dpo_state_t;

  localparam dpo_state_t STATE_RST = '{phase: DPO_PH_STRAP, ctrl: CTRL_RST, imask: INT_MASK_RST,
                                       pass: 1'b1, default: '0};

  dpo_state_t q;
  dpo_state_t d;
  logic rise;
  logic fall;
  logic running;
  logic awake;
  logic launch;
  logic lf_eff;
  logic rfb_eff;
  logic oss_eff;
  logic [3:0] ev;
  logic [3:0] ists_clr;

  dpo_ctl_if ctl_de();
  dpo_ctl_if ctl_hs();
  dpo_ctl_if ctl_vs();

  // ****************************************
  // Link clock edges and wake state
  // ****************************************
  assign rise = q.lk[1] & ~q.lk[2];
  assign fall = ~q.lk[1] & q.lk[2];
  assign running = q.phase == DPO_PH_RUN;
  // Awake only when powered and locked
  assign awake = running && q.pdn2 && q.lok2;
  assign lf_eff = q.ctrl[CTRL_LF_OVR] ? q.ctrl[CTRL_LF_VAL] : q.s_lf;
  assign rfb_eff = q.ctrl[CTRL_RFB_OVR] ? q.ctrl[CTRL_RFB_VAL] : q.s_rfb;
  assign oss_eff = q.ctrl[CTRL_OSS_OVR] ? q.ctrl[CTRL_OSS_VAL] : q.s_oss;
  assign launch = rfb_eff ? fall : rise;

  // ****************************************
  // Control filters
  // ****************************************
  assign ctl_de.stb = fall && running;
  assign ctl_hs.stb = fall && running;
  assign ctl_vs.stb = fall && running;
  assign ctl_de.raw = q.cap[CAP_DE];
  assign ctl_hs.raw = q.cap[CAP_HS];
  assign ctl_vs.raw = q.cap[CAP_VS];
  assign ctl_de.filt_en = q.mode == DPO_MODE_FILT_ON;
  assign ctl_hs.filt_en = q.mode == DPO_MODE_FILT_ON;
  assign ctl_vs.filt_en = 1'b0;

  dpo_ctl_filter #(.MAX_TRANS(DE_HS_MAX_TRANS)) u_filt_de
  (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .ctl(ctl_de)
  );

  dpo_ctl_filter #(.MAX_TRANS(DE_HS_MAX_TRANS)) u_filt_hs
  (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .ctl(ctl_hs)
  );

  dpo_ctl_filter #(.MAX_TRANS(VS_MAX_TRANS)) u_filt_vs
  (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .ctl(ctl_vs)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.lk = {q.lk[1:0], LINK_CLK};
    d.pdn1 = POWER_DOWN_N;
    d.pdn2 = q.pdn1;
    d.lok1 = PLL_LOCKED;
    d.lok2 = q.lok1;
    d.bist1 = BIST_EN;
    d.bist2 = q.bist1;
    d.err1 = RX_ERROR;
    d.err2 = q.err1;
    d.ssc1 = SSCG_EN;
    d.ssc2 = q.ssc1;
    d.rx1 = {RX_VS, RX_HS, RX_DE, RX_DATA};
    d.rx2 = q.rx1;
    d.din1 = DO_IN;
    d.din2 = q.din1;
    case (q.phase)
      DPO_PH_STRAP:
      begin
        d.doe = 1'b0;
        d.coe = 1'b0;
        if (q.scnt == STRAP_CW'(STRAP_CYC))
        begin
          d.mode = {q.din2[STRAP_CFG1_BIT], q.din2[STRAP_CFG0_BIT]};
          d.s_lf = q.din2[STRAP_LF_BIT];
          d.s_oss = q.din2[STRAP_OSS_BIT];
          d.s_rfb = q.din2[STRAP_RFB_BIT];
          d.phase = DPO_PH_RUN;
        end
        else
        begin
          d.scnt = q.scnt + 1'b1;
        end
      end
      DPO_PH_RUN:
      begin
        if (awake)
        begin
          d.doe = 1'b1;
          d.coe = 1'b1;
        end
        else
        begin
          d.doe = oss_eff;
          d.coe = oss_eff;
        end
      end
      default:
      begin
        d.phase = DPO_PH_STRAP;
      end
    endcase
    if (fall && running)
    begin
      d.cap = q.rx2;
    end
    if (!awake)
    begin
      d.dout = '0;
      d.de = 1'b0;
      d.hs = 1'b0;
      d.vs = 1'b0;
      d.pck = 1'b0;
    end
    else
    begin
      d.pck = q.lk[1];
      if (launch)
      begin
        d.dout = q.cap[DATA_W-1:0];
        d.de = ctl_de.fwd;
        d.hs = ctl_hs.fwd;
        d.vs = ctl_vs.fwd;
      end
    end
    d.lock = awake;
    if (!q.bist2)
      d.pass = 1'b1;
    else if (q.err2)
      d.pass = 1'b0;
    d.lowr = q.ssc2 & lf_eff;
    ev = '0;
    ev[INT_LOCK] = d.lock != q.lock;
    ev[INT_BIST] = q.pass & ~d.pass;
    ev[INT_DROP] = ctl_de.drop | ctl_hs.drop;
    ev[INT_RATE] = ctl_de.viol | ctl_hs.viol | ctl_vs.viol;
    ists_clr = '0;
    if (WR)
    begin
      case (ADDR)
        ADDR_CTRL: d.ctrl = WDATA[5:0];
        ADDR_INT_STAT: ists_clr = WDATA[3:0];
        ADDR_INT_MASK: d.imask = WDATA[3:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    d.ists = (q.ists & ~ists_clr) | ev;
    d.rdata = '0;
    if (RD)
    begin
      case (ADDR)
        ADDR_CTRL: d.rdata = {26'h0000000, q.ctrl};
        ADDR_STATUS: d.rdata = {24'h000000, running, oss_eff, rfb_eff, lf_eff, q.pass, q.lock, q.mode};
        ADDR_INT_STAT: d.rdata = {28'h0000000, q.ists};
        ADDR_INT_MASK: d.rdata = {28'h0000000, q.imask};
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      q <= STATE_RST;
    else
      q <= d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign DO_OUT = q.dout;
  assign DO_OE = {DATA_W{q.doe}};
  assign DATA_ENABLE_OUT = q.de;
  assign HSYNC_OUT = q.hs;
  assign VSYNC_OUT = q.vs;
  assign PIXEL_CLOCK_OUT = q.pck;
  assign CTRL_OE = q.coe;
  assign LOCK_OUT = q.lock;
  assign PASS_OUT = q.pass;
  assign SPREAD_LOW_RANGE = q.lowr;
  assign IRQ = |(q.ists & q.imask);
  assign RDATA = q.rdata;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_launch;
    awake ##1 awake && $changed(q.dout);
  endsequence

  sequence s_straps_taken;
    running ##1 running;
  endsequence

  a_colour_groups: assert property (
    $past(awake && launch) && awake |-> DO_OUT[7:0] == $past(q.cap[7:0]) && DO_OUT[15:8] == $past(q.cap[15:8])
      && DO_OUT[23:16] == $past(q.cap[23:16]))
    else $error("colour group not placed on its pins");
  a_sleep_outputs: assert property (
    running && !awake ##1 running |-> DO_OUT == '0 && PIXEL_CLOCK_OUT == 1'b0 && DO_OE == {DATA_W{$past(oss_eff)}})
    else $error("sleep outputs do not follow sleep select");
  a_strap_inputs: assert property (
    !running |-> DO_OE == '0 && CTRL_OE == 1'b0)
    else $error("data pins driven during strap phase");
  a_strap_frozen: assert property (
    s_straps_taken |-> $stable({q.mode, q.s_lf, q.s_oss, q.s_rfb}))
    else $error("strap value changed after power-up");
  a_mode_filter: assert property (
    running |-> ctl_de.filt_en == (q.mode == 2'h1) && !ctl_vs.filt_en)
    else $error("filter enable does not match mode");
  a_edge_select: assert property (
    s_launch |-> PIXEL_CLOCK_OUT == !$past(rfb_eff))
    else $error("data launched on the strobe edge");
  a_lock_active: assert property (
    ##1 LOCK_OUT == $past(running && q.pdn2 && q.lok2) && (!LOCK_OUT || DO_OE == '1))
    else $error("lock does not match active outputs");
  a_pass_sticky: assert property (
    q.bist2 && q.err2 ##1 q.bist2 [*2] |-> !PASS_OUT)
    else $error("pass flag recovered during self-test error");
  a_low_range: assert property (
    ##1 SPREAD_LOW_RANGE == $past(q.ssc2 && lf_eff))
    else $error("spread range select wrong");
endmodule

// *** dpo_display_model.sv ***
// Board pins and display sink facing the parallel output port
`timescale 1ns/1ps
module dpo_display_model
  import dpo_pkg::*;
(
  input wire logic [DATA_W-1:0] pull_up,
  input wire logic [DATA_W-1:0] do_out,
  input wire logic [DATA_W-1:0] do_oe,
  input wire logic pix_clk,
  input wire logic edge_sel,
  output logic [DATA_W-1:0] do_in,
  output logic [DATA_W-1:0] pixel
);
  always_comb
  begin
    for (int i = 0; i < DATA_W; i++)
    begin
      do_in[i] = do_oe[i] ? do_out[i] : pull_up[i];
    end
  end
  // Capture on the selected strobe edge
  always @(posedge pix_clk)
  begin
    if (edge_sel)
    begin
      pixel <= do_out;
    end
  end
  always @(negedge pix_clk)
  begin
    if (!edge_sel)
    begin
      pixel <= do_out;
    end
  end
endmodule

// *** test_dpo_parallel_out.sv ***
// Self-checking bench for the parallel output port
`timescale 1ns/1ps
module test_dpo_parallel_out
  import dpo_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic pd_n = 1'b1;
  logic locked = 1'b0;
  logic link_clk = 1'b0;
  logic [DATA_W-1:0] rx_data = 24'h000000;
  logic rx_de = 1'b0;
  logic rx_hs = 1'b0;
  logic rx_vs = 1'b0;
  logic bist = 1'b0;
  logic rx_err = 1'b0;
  logic sscg = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic [DATA_W-1:0] pix = 24'h000000;
  logic de = 1'b0;
  logic hs = 1'b0;
  logic vs = 1'b0;
  logic edge_sel = 1'b1;
  logic [DATA_W-1:0] straps = 24'h960000;
  logic [DATA_W-1:0] do_in, do_out, do_oe, pixel;
  logic de_o, hs_o, vs_o, pclk, ctrl_oe, lock_o, pass_o, low_rng, irq;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  initial
  begin
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #37;
    forever #200 link_clk = ~link_clk;
  end
  always @(posedge link_clk)
  begin
    rx_data <= pix;
    rx_de <= de;
    rx_hs <= hs;
    rx_vs <= vs;
  end

  dpo_parallel_out i_dpo_parallel_out (.MCLK(mclk), .RESET_N(reset_n), .POWER_DOWN_N(pd_n),
    .PLL_LOCKED(locked), .LINK_CLK(link_clk), .RX_DATA(rx_data), .RX_DE(rx_de), .RX_HS(rx_hs),
    .RX_VS(rx_vs), .BIST_EN(bist), .RX_ERROR(rx_err), .SSCG_EN(sscg), .DO_IN(do_in),
    .DO_OUT(do_out), .DO_OE(do_oe), .DATA_ENABLE_OUT(de_o), .HSYNC_OUT(hs_o), .VSYNC_OUT(vs_o),
    .PIXEL_CLOCK_OUT(pclk), .CTRL_OE(ctrl_oe), .LOCK_OUT(lock_o), .PASS_OUT(pass_o),
    .SPREAD_LOW_RANGE(low_rng), .IRQ(irq), .ADDR(addr), .WDATA(wdata), .WR(wstb), .RD(rstb),
    .RDATA(rdata));
  dpo_display_model i_dpo_display_model (.pull_up(straps), .do_out(do_out), .do_oe(do_oe),
    .pix_clk(pclk), .edge_sel(edge_sel), .do_in(do_in), .pixel(pixel));

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic lnk(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge mclk);
    wstb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge mclk);
    rstb <= 1'b0;
    #1;
    chk({32'h00000000, rdata & m}, {32'h00000000, exp});
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch++;
      test_done;
    end
  end

  initial
  begin
    cyc(3);
    chk({lock_o, pass_o, ctrl_oe, do_oe}, {3'h2, 24'h000000});
    repeat (9) @(posedge mclk);
    reset_n <= 1'b1;
    cyc(3);
    chk(do_oe, 24'h000000);
    rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h00000000);
    rd(ADDR_INT_MASK, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h10, 32'hFFFFFFFF, 32'h00000000);
    cyc(25);
    chk({lock_o, do_oe, do_out}, {1'b0, 24'hFFFFFF, 24'h000000});
    @(posedge mclk) locked <= 1'b1;
    cyc(8);
    rd(ADDR_STATUS, 32'h000000FF, 32'h000000FD);
    for (int e = 1; e >= 0; e--)
    begin
      edge_sel = e[0];
      wr(ADDR_CTRL, {28'h0000000, e[0], 3'h4});
      pix = e[0] ? 24'h0A8E5B : 24'hC3A512;
      lnk(5);
      chk(pixel, pix);
      chk({lock_o, do_oe, do_out}, {1'b1, 24'hFFFFFF, pix});
    end
    wr(ADDR_CTRL, 32'h00000000);
    edge_sel = 1'b1;
    hs = 1'b1;
    lnk(1);
    hs = 1'b0;
    lnk(8);
    chk(hs_o, 1'b0);
    hs = 1'b1;
    lnk(8);
    chk(hs_o, 1'b1);
    hs = 1'b0;
    lnk(8);
    chk(hs_o, 1'b0);
    hs = 1'b1;
    lnk(8);
    chk(hs_o, 1'b0);
    hs = 1'b0;
    vs = 1'b1;
    lnk(8);
    chk(vs_o, 1'b1);
    vs = 1'b0;
    lnk(8);
    chk(vs_o, 1'b1);
    vs = 1'b1;
    lnk(4);
    rd(ADDR_INT_STAT, 32'h0000000C, 32'h0000000C);
    wr(ADDR_INT_MASK, 32'h00000008);
    cyc(2);
    chk(irq, 1'b1);
    wr(ADDR_INT_STAT, 32'h00000008);
    cyc(2);
    chk(irq, 1'b0);
    rd(ADDR_INT_STAT, 32'h00000008, 32'h00000000);
    @(posedge mclk) bist <= 1'b1;
    @(posedge mclk) rx_err <= 1'b1;
    @(posedge mclk) rx_err <= 1'b0;
    cyc(6);
    chk(pass_o, 1'b0);
    rd(ADDR_INT_STAT, 32'h00000002, 32'h00000002);
    @(posedge mclk) bist <= 1'b0;
    cyc(6);
    chk(pass_o, 1'b1);
    @(posedge mclk) sscg <= 1'b1;
    cyc(6);
    chk(low_rng, 1'b1);
    wr(ADDR_CTRL, 32'h00000001);
    cyc(2);
    chk(low_rng, 1'b0);
    wr(ADDR_CTRL, 32'h00000003);
    cyc(2);
    chk(low_rng, 1'b1);
    @(posedge mclk) sscg <= 1'b0;
    cyc(6);
    chk(low_rng, 1'b0);
    wr(ADDR_CTRL, 32'h00000000);
    @(posedge mclk) pd_n <= 1'b0;
    cyc(8);
    chk({ctrl_oe, pclk, do_oe, do_out, de_o, hs_o, vs_o}, {2'h2, 24'hFFFFFF, 27'h0000000});
    wr(ADDR_CTRL, 32'h00000010);
    cyc(2);
    chk({ctrl_oe, do_oe}, 25'h0000000);
    // Second power-up with the filter strapped off
    @(posedge mclk) reset_n <= 1'b0;
    @(posedge mclk) pd_n <= 1'b1;
    @(posedge mclk) straps <= 24'h160000;
    @(posedge mclk) reset_n <= 1'b1;
    cyc(30);
    rd(ADDR_STATUS, 32'h000000FF, 32'h000000FC);
    hs = 1'b1;
    lnk(1);
    hs = 1'b0;
    lnk(3);
    chk(hs_o, 1'b1);
    lnk(4);
    chk(hs_o, 1'b0);
    rd(ADDR_INT_STAT, 32'h00000004, 32'h00000000);
    test_done;
  end
endmodule
